// *** design/port_chip_select_decoder.sv ***
// Purpose: Eight-pin port where each of the lower four pins is a data bit or a decoded chip-select strobe
// Assumes: External bus strobes and address are synchronous to clk, active high
// Notes:   Strobe pins follow the bus strobe with one register stage
`timescale 1ns/1ps
`default_nettype none

module port_chip_select_decoder #(
    parameter int PINS = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] ext_addr,
    input  wire logic        ext_read,
    input  wire logic        ext_write,
    output logic [7:0]       port_out
);

    // All block state in one record
    // Bus side: write address and data halves are captured separately
    // so that the master may offer them in either order or together.
    // A held half lowers its ready until the commit frees it again.
    // Response side: one write response and one read answer at most,
    // each standing until the master takes it.
    // Register side: option, polarity, data and base bytes.
    // Pin side: the registered image of all eight port pins, so that
    // every pin leaves the block straight from a flop.
    // Base bytes are packed per pin, pin n in bits 8n+7 down to 8n.
    // Polarity keeps only its upper nibble; the lower bits stay zero.
    // Port data bits 7:4 pass through to the upper pins unchanged.
    typedef struct packed {
        logic                 aw_have;
        logic [9:0]           aw_idx;
        logic                 aw_bad;
        logic                 w_have;
        logic [7:0]           w_byte;
        logic                 w_en;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [7:0]           polarity;
        logic [7:0]           opt_low;
        logic [7:0]           opt_high;
        logic [7:0]           port_data;
        logic [PINS*8-1:0]    base_high;
        logic [PINS*8-1:0]    base_low;
        logic [7:0]           pins;
    } state_type;

    state_type state_q;     // Registered state
    state_type state_d;     // Next state
    logic [PINS-1:0] pin_value;   // Combinational pin levels
    logic [7:0]      read_word;   // Read mux result
    logic            read_bad;    // Unmapped read

    // Per-pin field extraction, address compare and strobe gating
    // Each pin repeats the same slice of logic:
    //   pick its function and compare-length fields,
    //   turn the length field into an address mask,
    //   compare the external address with the pin's base under that mask,
    //   gate the hit with the qualifying bus strobe,
    //   then apply the pin's polarity or fall back to the data bit.
    // The compare uses the live bus address and strobes, so a strobe
    // pin tracks the bus cycle with only the output register between.
    // Nothing here holds state; every flop lives in the state record.
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            logic [1:0]  func;
            logic [1:0]  cmp;
            logic [15:0] mask;
            logic [15:0] base;
            logic        hit;
            logic        active;
            // Upper pin of each pair sits in bits 7:4
            always_comb begin
                if (gi == 3) begin
                    func = state_q.opt_high[port_strobe_pkg::FUNC_SHIFT_UPPER +: 2];
                    cmp  = state_q.opt_high[port_strobe_pkg::CMP_SHIFT_UPPER +: 2];
                end else if (gi == 2) begin
                    func = state_q.opt_high[port_strobe_pkg::FUNC_SHIFT_LOWER +: 2];
                    cmp  = state_q.opt_high[port_strobe_pkg::CMP_SHIFT_LOWER +: 2];
                end else if (gi == 1) begin
                    func = state_q.opt_low[port_strobe_pkg::FUNC_SHIFT_UPPER +: 2];
                    cmp  = state_q.opt_low[port_strobe_pkg::CMP_SHIFT_UPPER +: 2];
                end else begin
                    func = state_q.opt_low[port_strobe_pkg::FUNC_SHIFT_LOWER +: 2];
                    cmp  = state_q.opt_low[port_strobe_pkg::CMP_SHIFT_LOWER +: 2];
                end
            end
            // Compare mask from the length field
            // A cleared mask bit removes that address bit from the match,
            // which widens the window the strobe answers to.
            // Widest window is one page of 256 addresses.
            // Narrowest window is one single address.
            always_comb begin
                case (cmp)
                    port_strobe_pkg::CMP_FULL:  mask = port_strobe_pkg::MASK_FULL;
                    port_strobe_pkg::CMP_DROP1: mask = port_strobe_pkg::MASK_DROP1;
                    port_strobe_pkg::CMP_DROP2: mask = port_strobe_pkg::MASK_DROP2;
                    default:                    mask = port_strobe_pkg::MASK_DROP8;
                endcase
            end
            // Base from its register pair
            assign base = {state_q.base_high[gi*8 +: 8], state_q.base_low[gi*8 +: 8]};
            assign hit  = ((ext_addr ^ base) & mask) == 16'h0000;
            // Strobe exists only while the qualifying bus strobe and match hold
            // Read-only pins ignore write cycles and the reverse.
            // Both-way pins answer either strobe.
            // Data mode never raises the internal strobe at all.
            // Dropping either the bus strobe or the match ends the strobe,
            // so each bus cycle gives one pulse and never a stretched one.
            always_comb begin
                case (func)
                    port_strobe_pkg::FUNC_READ:  active = hit && ext_read;
                    port_strobe_pkg::FUNC_WRITE: active = hit && ext_write;
                    port_strobe_pkg::FUNC_BOTH:  active = hit && (ext_read || ext_write);
                    default:                     active = 1'b0;
                endcase
            end
            // Mode 0 drives the data bit, else strobe with polarity
            // Polarity one gives an active-high strobe, zero an active-low one.
            // An idle active-low strobe therefore rests high, which is the
            // same level a released data pin shows after reset.
            // Changing mode while a bus cycle runs may cut that pulse short.
            always_comb begin
                if (func == port_strobe_pkg::FUNC_GPIO) begin
                    pin_value[gi] = state_q.port_data[gi];
                end else begin
                    // Inactive level returns as soon as active drops
                    pin_value[gi] = state_q.polarity[port_strobe_pkg::POL_SHIFT + gi] ?
                                    active : !active;
                end
            end
        end
    endgenerate

    // Register read mux by word index
    // Registers sit one to a 32-bit word; only byte 0 carries data.
    // Byte address bits 1:0 are ignored, so any byte offset reads the word.
    // Base registers alternate high and low from the first base index:
    //   even index is a pin's high byte, odd index its low byte.
    // Any index outside the map answers with an error and zero data,
    // so software sees a bad offset rather than a silent alias.
    // The mux looks at the live read address; the answer is registered
    // at the edge that takes the request, so a later change of the
    // address cannot disturb data already handed back.
    always_comb begin
        logic [9:0] ridx;
        ridx      = s_axi_araddr[11:2];
        read_word = 8'h00;
        read_bad  = 1'b0;
        if (ridx == {2'b00, port_strobe_pkg::IDX_POLARITY}) begin
            read_word = {state_q.polarity[7:4], 4'h0};
        end else if (ridx == {2'b00, port_strobe_pkg::IDX_OPT_LOW}) begin
            read_word = state_q.opt_low;
        end else if (ridx == {2'b00, port_strobe_pkg::IDX_OPT_HIGH}) begin
            read_word = state_q.opt_high;
        end else if (ridx == {2'b00, port_strobe_pkg::IDX_PORT_DATA}) begin
            read_word = state_q.port_data;
        end else if (ridx >= {2'b00, port_strobe_pkg::IDX_BASE0} &&
                     ridx < {2'b00, port_strobe_pkg::IDX_BASE0} + 10'(2 * PINS)) begin
            if (ridx[0] == 1'b0) begin
                read_word = state_q.base_high[(ridx[3:1] - 3'h0) * 8 +: 8];
            end else begin
                read_word = state_q.base_low[ridx[3:1] * 8 +: 8];
            end
        end else begin
            read_bad = 1'b1;
        end
    end

    // Next-state logic: bus handshakes, register writes, pin register
    // Order of the steps below matters only where two touch one field:
    //   a later step overrides an earlier one in the same cycle.
    // Write address and data are each taken at their own handshake edge.
    // The commit waits for both halves and for a free response slot,
    // so a master that is slow to take responses simply stalls writes.
    // A write response and the next commit never meet in one cycle,
    // because the commit needs the response slot to be empty first.
    // Reads are taken whenever no read answer stands, independent of
    // anything the write side is doing.
    // The pin image is refreshed every enabled cycle from the pin logic.
    // With the clock enable low nothing here reaches the registers.
    always_comb begin
        state_d = state_q;
        // Pins registered so outputs come from flops
        state_d.pins = {state_q.port_data[7:PINS], pin_value};
        // Write address capture
        if (!state_q.aw_have && s_axi_awvalid) begin
            state_d.aw_have = 1'b1;
            state_d.aw_idx  = s_axi_awaddr[11:2];
            state_d.aw_bad  = 1'b1;
            if (s_axi_awaddr[11:2] == {2'b00, port_strobe_pkg::IDX_POLARITY} ||
                s_axi_awaddr[11:2] == {2'b00, port_strobe_pkg::IDX_OPT_LOW} ||
                s_axi_awaddr[11:2] == {2'b00, port_strobe_pkg::IDX_OPT_HIGH} ||
                s_axi_awaddr[11:2] == {2'b00, port_strobe_pkg::IDX_PORT_DATA} ||
                (s_axi_awaddr[11:2] >= {2'b00, port_strobe_pkg::IDX_BASE0} &&
                 s_axi_awaddr[11:2] < {2'b00, port_strobe_pkg::IDX_BASE0} + 10'(2 * PINS))) begin
                state_d.aw_bad = 1'b0;
            end
        end
        // Write data capture
        if (!state_q.w_have && s_axi_wvalid) begin
            state_d.w_have = 1'b1;
            state_d.w_byte = s_axi_wdata[7:0];
            state_d.w_en   = s_axi_wstrb[0];
        end
        // Commit once both halves are held and no response is pending
        // Bad offsets give an error and leave every register untouched.
        // A cleared byte-0 strobe gives OKAY but writes nothing.
        // Register writes become visible one edge after the commit, and
        // the pins follow one edge later still through the pin image.
        // Both held halves are released together here.
        if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
            state_d.aw_have = 1'b0;
            state_d.w_have  = 1'b0;
            state_d.bvalid  = 1'b1;
            state_d.bresp   = state_q.aw_bad ? port_strobe_pkg::RESP_SLVERR
                                             : port_strobe_pkg::RESP_OKAY;
            if (state_q.w_en && !state_q.aw_bad) begin
                if (state_q.aw_idx == {2'b00, port_strobe_pkg::IDX_POLARITY}) begin
                    state_d.polarity = {state_q.w_byte[7:4], 4'h0};
                end else if (state_q.aw_idx == {2'b00, port_strobe_pkg::IDX_OPT_LOW}) begin
                    state_d.opt_low = state_q.w_byte;
                end else if (state_q.aw_idx == {2'b00, port_strobe_pkg::IDX_OPT_HIGH}) begin
                    state_d.opt_high = state_q.w_byte;
                end else if (state_q.aw_idx == {2'b00, port_strobe_pkg::IDX_PORT_DATA}) begin
                    state_d.port_data = state_q.w_byte;
                end else if (state_q.aw_idx[0] == 1'b0) begin
                    state_d.base_high[state_q.aw_idx[3:1] * 8 +: 8] = state_q.w_byte;
                end else begin
                    state_d.base_low[state_q.aw_idx[3:1] * 8 +: 8] = state_q.w_byte;
                end
            end
        end
        // Write response retire
        if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end
        // Read: accept when no read data pending
        // Upper data bits always read zero.
        // The read ready is the inverse of the pending answer, so a new
        // read is only taken in the cycle after the last one retired.
        if (!state_q.rvalid && s_axi_arvalid) begin
            state_d.rvalid = 1'b1;
            state_d.rdata  = {24'h000000, read_word};
            state_d.rresp  = read_bad ? port_strobe_pkg::RESP_SLVERR
                                      : port_strobe_pkg::RESP_OKAY;
        end else if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
    end

    // State register with synchronous reset and clock enable
    // Reset wins over the clock enable, so a frozen block still resets.
    // After reset every pin is in data mode and every data bit is one,
    // so the pins rest high until software programs them.
    // Option, polarity and base bytes clear to zero.
    // Both response slots are empty and all readies are high.
    // The first request may come at the first edge after release.
    // With the enable low every flop keeps its value, bus handshakes
    // included, but a ready left high still lets a handshake complete that the block then drops.
    // Only constants are loaded in the reset branch.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q           <= '0;
            state_q.polarity  <= port_strobe_pkg::RESET_CFG;
            state_q.opt_low   <= port_strobe_pkg::RESET_CFG;
            state_q.opt_high  <= port_strobe_pkg::RESET_CFG;
            state_q.base_high <= '0;
            state_q.base_low  <= '0;
            state_q.port_data <= port_strobe_pkg::RESET_PORT;
            state_q.pins      <= port_strobe_pkg::RESET_PORT;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    // Readies are plain inversions of held flags, with no input in the
    // path, so no combinational loop can form through the master.
    // Response codes and read data stand with their valid flags.
    // The port pins are the registered pin image in full.
    // Upper pins show port data bits 7:4 at all times.
    assign s_axi_awready = !state_q.aw_have;
    assign s_axi_wready  = !state_q.w_have;
    assign s_axi_bvalid  = state_q.bvalid;
    assign s_axi_bresp   = state_q.bresp;
    assign s_axi_arready = !state_q.rvalid;
    assign s_axi_rvalid  = state_q.rvalid;
    assign s_axi_rdata   = state_q.rdata;
    assign s_axi_rresp   = state_q.rresp;
    assign port_out      = state_q.pins;

endmodule : port_chip_select_decoder

`default_nettype wire

// *** design/port_strobe_pkg.sv ***
// Purpose: Constants for the four-pin strobe decoder port
// Assumes: AXI4-Lite register access, byte address = 4 * register index
// Notes:   Register indices are kept as printed; base registers use chosen indices
package port_strobe_pkg;
    // Register indices
    localparam logic [7:0] IDX_POLARITY  = 8'hae;
    localparam logic [7:0] IDX_OPT_LOW   = 8'hc2;
    localparam logic [7:0] IDX_OPT_HIGH  = 8'hc3;
    localparam logic [7:0] IDX_PORT_DATA = 8'hd8;
    localparam logic [7:0] IDX_BASE0     = 8'he0;  // Pin n high at e0+2n, low at e1+2n
    // Field positions
    localparam int FUNC_SHIFT_UPPER = 6;
    localparam int CMP_SHIFT_UPPER  = 4;
    localparam int FUNC_SHIFT_LOWER = 2;
    localparam int CMP_SHIFT_LOWER  = 0;
    localparam int POL_SHIFT        = 4;
    // Reset values
    localparam logic [7:0] RESET_CFG  = 8'h00;
    localparam logic [7:0] RESET_PORT = 8'hff;
    // Function encodings
    localparam logic [1:0] FUNC_GPIO  = 2'h0;
    localparam logic [1:0] FUNC_READ  = 2'h1;
    localparam logic [1:0] FUNC_WRITE = 2'h2;
    localparam logic [1:0] FUNC_BOTH  = 2'h3;
    // Compare-length encodings
    localparam logic [1:0] CMP_FULL   = 2'h0;
    localparam logic [1:0] CMP_DROP1  = 2'h1;
    localparam logic [1:0] CMP_DROP2  = 2'h2;
    localparam logic [1:0] CMP_DROP8  = 2'h3;
    localparam logic [15:0] MASK_FULL  = 16'hffff;
    localparam logic [15:0] MASK_DROP1 = 16'hfffe;
    localparam logic [15:0] MASK_DROP2 = 16'hfffc;
    localparam logic [15:0] MASK_DROP8 = 16'hff00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : port_strobe_pkg

// *** test/port_chip_select_decoder_test.sv ***
// Purpose: Self-checking bench for the strobe decoder port
// Assumes: All inputs driven just after rising edges
// Notes:   Drivers queue expectations; a monitor compares answers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module port_chip_select_decoder_test;
    localparam logic [31:0] zero = 32'h0;
    logic        clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, peri_rst_n = 1'h0, look = 1'h0, pol;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_read = 1'h0, ext_write = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, qb[$], qr[$], qp[$], qs[$];
    logic [15:0] ext_addr = 16'h0, base, m, ina, outa;
    logic [7:0]  port_out, pd, e;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, f, c;
    int          fail_count = 0, check_count = 0, pulses, p, k, n;
    port_chip_select_decoder port_chip_select_decoder_i (.*);
    strobe_peripheral strobe_peripheral_i (.clk(clk), .rst_n(peri_rst_n),
        .select_pin(port_out[0]), .active_high(1'h1), .pulses(pulses));
    always #20 clk = ~clk;
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // One register access; x is the expected response code or read data
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, x);
        int i;
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a; s_axi_awvalid <= 1'h1; s_axi_wdata <= d;
            s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1; qb.push_back(x);
        end else begin
            s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1; qr.push_back(x);
            qs.push_back((a == 12'h004) ? 32'h2 : zero);
        end
        for (i = 0; i < 20 && !(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready);
             i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        if (i == 20) begin fail_count++; tally_and_finish(); end
        s_axi_bready <= 1'h0; s_axi_rready <= 1'h0;
    endtask : acc
    // Hold one external bus state, then look at the pins it caused
    task automatic pin(input logic [15:0] a, input logic r, w, input logic [7:0] x);
        @(posedge clk);
        ext_addr <= a; ext_read <= r; ext_write <= w;
        @(posedge clk);
        qp.push_back({24'h0, x}); look <= 1'h1;
        @(posedge clk);
        look <= 1'h0;
    endtask : pin
    // Compare the oldest note with each answer as it appears
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready) begin v = qb.pop_front(); `CHK("bresp", v, {30'h0, s_axi_bresp}) end
        if (s_axi_rvalid && s_axi_rready) begin
            v = qr.pop_front(); `CHK("rdata", v, s_axi_rdata)
            v = qs.pop_front(); `CHK("rresp", v, {30'h0, s_axi_rresp})
        end
        if (look) begin v = qp.pop_front(); `CHK("port_out", v, {24'h0, port_out}) end
    end
    initial begin
        void'($urandom(32'h20df));
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        acc(0, 12'h2b8, zero, zero); acc(0, 12'h308, zero, zero); acc(0, 12'h30c, zero, zero);
        acc(0, 12'h380, zero, zero); acc(0, 12'h39c, zero, zero); acc(0, 12'h360, zero, 32'hff);
        acc(1, 12'h004, 32'h5a, 32'h2); acc(0, 12'h004, zero, zero);
        acc(1, 12'h2b8, 32'hff, zero); acc(0, 12'h2b8, zero, 32'hf0);
        pd = 8'($urandom);
        acc(1, 12'h360, {24'h0, pd}, zero); acc(0, 12'h360, zero, {24'h0, pd});
        pin(16'h0, 1'h0, 1'h0, pd);
        // Every pin, strobe function and compare length
        for (p = 0; p < 4; p++) for (k = 4; k < 16; k++) begin
            {f, c} = 4'(k); base = 16'($urandom); pol = 1'($urandom);
            m = (c == 2'h3) ? 16'hff00 : 16'hffff << c;
            ina = (base & m) | (16'($urandom) & ~m);
            outa = ina ^ ((c == 2'h3) ? 16'h0100 : 16'h0001 << c);
            acc(1, 12'(12'h380 + 8 * p), {24'h0, base[15:8]}, zero);
            acc(1, 12'(12'h384 + 8 * p), {24'h0, base[7:0]}, zero);
            acc(0, 12'(12'h384 + 8 * p), zero, {24'h0, base[7:0]});
            acc(1, 12'h308, (p < 2) ? 32'({f, c}) << (4 * p) : zero, zero);
            acc(1, 12'h30c, (p > 1) ? 32'({f, c}) << (4 * p - 8) : zero, zero);
            acc(1, 12'h2b8, 32'(pol) << (4 + p), zero);
            for (n = 0; n < 5; n++) begin
                e = pd;
                e[p] = ~pol ^ (n < 2 && (n[0] ? f[1] : f[0]));
                pin(n[1] ? outa : ina, n < 4 && !n[0], n < 4 && n[0], e);
            end
        end
        // Write strobe on pin 0 over a four-byte window, high active
        acc(1, 12'h380, 32'h12, zero); acc(1, 12'h384, 32'h34, zero); acc(1, 12'h308, 32'h0a, zero);
        acc(1, 12'h30c, zero, zero); acc(1, 12'h2b8, 32'h10, zero);
        peri_rst_n <= 1'h1;
        for (n = 0; n < 6; n++) begin
            pin(16'h1234 + 16'(n), n == 4, n != 4, {pd[7:1], n < 4});
            pin(16'h1234, 1'h0, 1'h0, {pd[7:1], 1'h0});
        end
        `CHK("pulses", 4, pulses)
        tally_and_finish();
    end
endmodule : port_chip_select_decoder_test
`undef CHK
`default_nettype wire

// *** test/port_strobe_asserts.sv ***
// Purpose: Port timing checks for the strobe decoder
// Assumes: Sees only top-level ports; clk_en held high
// Notes:   Bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module port_strobe_asserts (
    input wire logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, ext_read, ext_write,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  port_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Bus handshakes
    property p_aw_take; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_take: assert property (p_aw_take) else $error("awready stayed high");
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
    property p_w_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_w_answer: assert property (p_w_answer) else $error("write not answered");
    property p_b_retire; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_retire: assert property (p_b_retire) else $error("bvalid not retired");
    property p_rdata_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("rdata upper bits set");
    // Pins
    property p_reset_pins; $rose(rst_n) |-> port_out == 8'hff; endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not high after reset");
    // Quiet bus and no register write keep every pin still
    property p_idle_stable;
        {ext_read, ext_write, $past({ext_read, ext_write}), $past({ext_read, ext_write}, 2)} == 6'h0
        && {s_axi_bvalid, $past(s_axi_bvalid), $past(s_axi_bvalid, 2)} == 3'h0 |-> $stable(port_out);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("pin moved on idle bus");
    property p_upper_nibble;
        $changed(port_out[7:4]) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_upper_nibble: assert property (p_upper_nibble) else $error("upper pins moved");
endmodule : port_strobe_asserts
bind port_chip_select_decoder port_strobe_asserts port_strobe_asserts_i (.*);
`default_nettype wire

// *** test/strobe_peripheral.sv ***
// Purpose: External peripheral counting its chip-select strobes
// Assumes: Strobe level sampled on the core clock
// Notes:   One count per entry into the active level
`timescale 1ns/1ps
`default_nettype none
module strobe_peripheral (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic select_pin,
    input  wire logic active_high,
    output var  int   pulses
);
    logic was_active;  // Strobe active last cycle
    // Count each new selection
    always @(posedge clk) begin
        was_active <= rst_n && (select_pin === active_high);
        if (!rst_n) pulses <= 0;
        else if (select_pin === active_high && !was_active) pulses <= pulses + 1;
    end
endmodule : strobe_peripheral
`default_nettype wire
